/* File: pkg/residual_pickup_pkg.sv */
package residual_pickup_pkg;

    // ==========================================================
    // data widths
    // ==========================================================
    localparam int MAG_W   = 24;  // magnitude in 1e-4 x nominal units
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 32;
    localparam int GROUP_W = 3;
    localparam int NGROUP  = 8;

    // ==========================================================
    // source and magnitude selections
    // ==========================================================
    typedef enum logic [1:0] {
        SRC_COARSE     = 2'h0,
        SRC_SENSITIVE  = 2'h1,
        SRC_CALCULATED = 2'h2
    } source_sel_t;

    typedef enum logic [1:0] {
        MAG_FUND_RMS   = 2'h0,
        MAG_TRUE_RMS   = 2'h1,
        MAG_PEAK_PEAK  = 2'h2
    } mag_sel_t;

    // reported condition codes
    typedef enum logic [1:0] {
        COND_NORMAL  = 2'h0,
        COND_START   = 2'h1,
        COND_TRIP    = 2'h2,
        COND_BLOCKED = 2'h3
    } condition_t;

    // ==========================================================
    // thresholds and hysteresis
    // ==========================================================
    localparam logic [MAG_W-1:0] THRESHOLD_DEFAULT = 24'h00_2EE0; // 1.2000 x In
    localparam int unsigned HYST_NUM = 97;
    localparam int unsigned HYST_DEN = 100;
    localparam int unsigned TRUE_RMS_HARMONICS = 32;
    localparam real REFRESH_MS = 5.0;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned REFRESH_CYCLES = int'(REFRESH_MS * 1000.0) * CLK_MHZ;

    // ==========================================================
    // register map (word addresses)
    // ==========================================================
    localparam logic [ADDR_W-1:0] REG_STATIC    = 4'h0;
    localparam logic [ADDR_W-1:0] REG_GROUP     = 4'h1;
    localparam logic [ADDR_W-1:0] REG_THR_LOCAL = 4'h2;
    localparam logic [ADDR_W-1:0] REG_THR_BUS   = 4'h3;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 4'h5;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN    = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR   = 4'h7;
    localparam logic [ADDR_W-1:0] REG_RATIO     = 4'h8;

    // static register fields
    localparam int F_SRC_LSB   = 0;
    localparam int F_MAG_LSB   = 2;
    localparam int F_FORCE_LSB = 4;
    localparam int F_FORCE_EN  = 6;
    localparam int F_BUS_EN    = 7;
    localparam int F_GFORCE    = 8;
    localparam logic [8:0] STATIC_RESET = 9'h000;

    // event bits
    localparam int NEVT = 4;
    localparam int EV_START_ON  = 0;
    localparam int EV_START_OFF = 1;
    localparam int EV_BLOCK_ON  = 2;
    localparam int EV_BUS_REJ   = 3;

    localparam int RATIO_SCALE = 1000; // ratio shown in thousandths
endpackage

/* File: src/residual_overcurrent_pickup.sv */
// Summary of operation
// RL1: pick one residual source, coarse default
// RL2: magnitude type for measured inputs only
// RL3: source refreshes values every 5 ms
// RL4: threshold in 1e-4 nominal, default 1.20
// RL5: compute ratio, pick up above threshold
// RL6: release below 97 percent of threshold
// RL7: force status override when forcing enabled
// RL8: bus threshold writes need bus control
// RL9: static selections ignore setting group
// RL10: threshold follows active group live
// RL11: sample block each cycle, raise start
// RL12: blocked at pick-up; later block clears start
// RL13: four-state condition, forcing takes precedence
//
// Decided for this implementation: the address-and-strobe port and the address map.
module residual_overcurrent_pickup
    import residual_pickup_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [MAG_W-1:0]    coarse_fund,
    input  wire logic [MAG_W-1:0]    coarse_true_rms_magnitude,
    input  wire logic [MAG_W-1:0]    coarse_pp,
    input  wire logic [MAG_W-1:0]    sens_fund,
    input  wire logic [MAG_W-1:0]    sens_true_rms_magnitude,
    input  wire logic [MAG_W-1:0]    sens_pp,
    input  wire logic [MAG_W-1:0]    calc_fund,
    input  wire logic                meas_valid,
    input  wire logic                block_in,
    input  wire logic                trip_in,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [DATA_W-1:0]   rdata,
    output logic                     start,
    output logic                     blocked,
    output logic      [1:0]          condition,
    output logic                     irq
);

    // ==========================================================
    // state
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_START   = 3'b010,
        ST_BLOCKED = 3'b100
    } fsm_t;

    typedef struct packed {
        fsm_t                           fsm;
        logic [8:0]                     static_cfg;
        logic [GROUP_W-1:0]             group;
        logic [NGROUP-1:0][MAG_W-1:0]   thr;
        logic [MAG_W-1:0]               mag;
        logic [MAG_W-1:0]               ratio;
        logic [NEVT-1:0]                irq_stat;
        logic [NEVT-1:0]                irq_en;
        logic [DATA_W-1:0]              rdata;
        logic [2:0]                     blk_sync;
        logic                           blk;
        logic [1:0]                     cond;
    } state_t;

    state_t st;
    state_t next_st;

    localparam state_t STATE_RESET = '{
        fsm:        ST_IDLE,
        static_cfg: STATIC_RESET,
        group:      '0,
        thr:        {NGROUP{THRESHOLD_DEFAULT}},
        mag:        '0,
        ratio:      '0,
        irq_stat:   '0,
        irq_en:     '0,
        rdata:      '0,
        blk_sync:   '0,
        blk:        1'b0,
        cond:       COND_NORMAL
    };

    // ==========================================================
    // selection and compare
    // ==========================================================
    source_sel_t       src;
    mag_sel_t          msel;
    logic [MAG_W-1:0]  sel_mag;
    logic [MAG_W-1:0]  act_thr;
    logic              above_set;
    logic              below_release;
    logic              force_on;

    // static fields never indexed by group
    assign src      = source_sel_t'(st.static_cfg[F_SRC_LSB +: 2]);
    assign msel     = mag_sel_t'(st.static_cfg[F_MAG_LSB +: 2]);
    // RL10: live group threshold
    assign act_thr  = st.thr[st.group];
    // RL7: forcing offered only when globally enabled
    assign force_on = st.static_cfg[F_FORCE_EN] & st.static_cfg[F_GFORCE];

    // RL1: one source; RL2: magnitude type ignored for calculated source
    always_comb
    begin
        case (src)
            SRC_SENSITIVE:
            begin
                case (msel)
                    MAG_TRUE_RMS:  sel_mag = sens_true_rms_magnitude;
                    MAG_PEAK_PEAK: sel_mag = sens_pp;
                    default:       sel_mag = sens_fund;
                endcase
            end
            SRC_CALCULATED: sel_mag = calc_fund;
            default:
            begin
                case (msel)
                    MAG_TRUE_RMS:  sel_mag = coarse_true_rms_magnitude;
                    MAG_PEAK_PEAK: sel_mag = coarse_pp;
                    default:       sel_mag = coarse_fund;
                endcase
            end
        endcase
    end

    // RL5: compare against threshold, RL6: release level
    threshold_compare u_cmp (
        .magnitude     (st.mag),
        .threshold     (act_thr),
        .above_set     (above_set),
        .below_release (below_release)
    );

    // ==========================================================
    // next-state logic
    // ==========================================================
    logic [NEVT-1:0]   ev;
    logic              bus_wr_ok;
    logic [MAG_W+9:0]  ratio_wide;

    always_comb
    begin
        next_st    = st;
        ev         = '0;
        bus_wr_ok  = 1'b0;
        ratio_wide = '0;
        // three-stage sampler, change counted when last two agree
        next_st.blk_sync = {st.blk_sync[1:0], block_in};
        if (st.blk_sync[2] == st.blk_sync[1])
        begin
            next_st.blk = st.blk_sync[2];
        end
        // RL3: fresh magnitude taken when the source marks it valid
        if (meas_valid)
        begin
            next_st.mag = sel_mag;
        end
        // RL5: ratio in thousandths; zero threshold shows zero
        if (act_thr != '0)
        begin
            ratio_wide  = ((MAG_W+10)'(st.mag) * (MAG_W+10)'(RATIO_SCALE)) / (MAG_W+10)'(act_thr);
            next_st.ratio = ratio_wide[MAG_W-1:0];
        end
        else
        begin
            next_st.ratio = '0;
        end

        // RL11: block sampled every cycle, start when unblocked
        case (st.fsm)
            ST_IDLE:
            begin
                if (above_set)
                begin
                    // RL12: block at pick-up gives blocked
                    if (st.blk)
                    begin
                        next_st.fsm = ST_BLOCKED;
                        ev[EV_BLOCK_ON] = 1'b1;
                    end
                    else
                    begin
                        next_st.fsm = ST_START;
                        ev[EV_START_ON] = 1'b1;
                    end
                end
            end
            ST_START:
            begin
                // RL6: release only below 97 percent
                if (below_release)
                begin
                    next_st.fsm = ST_IDLE;
                    ev[EV_START_OFF] = 1'b1;
                end
                // RL12: later block clears start
                else if (st.blk)
                begin
                    next_st.fsm = ST_BLOCKED;
                    ev[EV_START_OFF] = 1'b1;
                    ev[EV_BLOCK_ON] = 1'b1;
                end
            end
            ST_BLOCKED:
            begin
                if (below_release)
                begin
                    next_st.fsm = ST_IDLE;
                end
                else if (!st.blk)
                begin
                    next_st.fsm = ST_START;
                    ev[EV_START_ON] = 1'b1;
                end
            end
            default: next_st.fsm = ST_IDLE;
        endcase

        // RL13: encoded condition, forcing wins
        if (force_on)
        begin
            next_st.cond = st.static_cfg[F_FORCE_LSB +: 2];
        end
        else if (next_st.fsm == ST_BLOCKED)
        begin
            next_st.cond = COND_BLOCKED;
        end
        else if (next_st.fsm == ST_START)
        begin
            next_st.cond = trip_in ? COND_TRIP : COND_START;
        end
        else
        begin
            next_st.cond = COND_NORMAL;
        end

        // register writes
        if (wr)
        begin
            case (addr)
                // RL9: static selections, no group index
                REG_STATIC:    next_st.static_cfg = wdata[8:0];
                REG_GROUP:     next_st.group = wdata[GROUP_W-1:0];
                // RL4: local threshold, 1e-4 nominal steps
                REG_THR_LOCAL: next_st.thr[st.group] = wdata[MAG_W-1:0];
                REG_THR_BUS:
                begin
                    // RL8: bus writes rejected unless allowed
                    if (st.static_cfg[F_BUS_EN])
                    begin
                        next_st.thr[st.group] = wdata[MAG_W-1:0];
                        bus_wr_ok = 1'b1;
                    end
                    else
                    begin
                        ev[EV_BUS_REJ] = 1'b1;
                    end
                end
                REG_IRQ_EN:    next_st.irq_en = wdata[NEVT-1:0];
                REG_IRQ_CLR:   next_st.irq_stat = st.irq_stat & ~wdata[NEVT-1:0];
                default:       next_st.irq_en = st.irq_en;
            endcase
        end
        // set wins over clear
        next_st.irq_stat = next_st.irq_stat | ev;

        // read data one cycle later
        next_st.rdata = '0;
        if (rd)
        begin
            case (addr)
                REG_STATIC:    next_st.rdata = DATA_W'(st.static_cfg);
                REG_GROUP:     next_st.rdata = DATA_W'(st.group);
                REG_THR_LOCAL: next_st.rdata = DATA_W'(act_thr);
                REG_THR_BUS:   next_st.rdata = DATA_W'(act_thr);
                REG_STATUS:    next_st.rdata = DATA_W'({st.blk, st.fsm, st.cond});
                REG_IRQ_STAT:  next_st.rdata = DATA_W'(st.irq_stat);
                REG_IRQ_EN:    next_st.rdata = DATA_W'(st.irq_en);
                REG_RATIO:     next_st.rdata = DATA_W'(st.ratio);
                default:       next_st.rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= STATE_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // rdata and condition straight from flip-flops; start, blocked and irq decoded from flip-flops
    assign rdata     = st.rdata;
    assign condition = st.cond;
    assign start     = (st.cond == COND_START) | (st.cond == COND_TRIP);
    assign blocked   = st.cond == COND_BLOCKED;
    assign irq       = |(st.irq_stat & st.irq_en);

    // ==========================================================
    // assertions
    // ==========================================================
    sequence s_unblocked_pickup;
        st.fsm == ST_IDLE && above_set && !st.blk;
    endsequence

    sequence s_blocked_pickup;
        st.fsm == ST_IDLE && above_set && st.blk;
    endsequence

    a_start_on_pickup: assert property (@(posedge clk) disable iff (!rst_n) // RL11
        s_unblocked_pickup |=> st.fsm == ST_START)
        else $error("pickup without block did not start");

    a_blocked_on_pickup: assert property (@(posedge clk) disable iff (!rst_n) // RL12
        s_blocked_pickup |=> st.fsm == ST_BLOCKED && st.irq_stat[EV_BLOCK_ON])
        else $error("pickup under block did not block");

    a_release_hysteresis: assert property (@(posedge clk) disable iff (!rst_n) // RL6
        st.fsm == ST_START && !below_release && !st.blk |=> st.fsm == ST_START)
        else $error("start released above release level");

    a_release_below: assert property (@(posedge clk) disable iff (!rst_n) // RL6
        st.fsm == ST_START && below_release |=> st.fsm == ST_IDLE)
        else $error("start held below release level");

    a_bus_reject: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        wr && addr == REG_THR_BUS && !st.static_cfg[F_BUS_EN] |=> $stable(st.thr))
        else $error("bus threshold write accepted while disabled");

    a_force_wins: assert property (@(posedge clk) disable iff (!rst_n) // RL13
        force_on && !(wr && addr == REG_STATIC) |=> condition == $past(st.static_cfg[F_FORCE_LSB +: 2]))
        else $error("forced status not shown");

    a_start_pickup_level: assert property (@(posedge clk) disable iff (!rst_n) // RL5
        st.fsm == ST_IDLE && !above_set |=> st.fsm == ST_IDLE)
        else $error("pickup without exceeding threshold");

    a_group_static: assert property (@(posedge clk) disable iff (!rst_n) // RL9
        wr && addr == REG_GROUP |=> $stable(st.static_cfg))
        else $error("group change altered static settings");

    // forcing owns the reported state, and a start may come back once the block falls
    a_block_clears: assert property (@(posedge clk) disable iff (!rst_n) // RL12
        st.fsm == ST_START && !below_release && st.blk && !force_on |=> blocked && !start)
        else $error("block did not clear start");

    a_src_select: assert property (@(posedge clk) disable iff (!rst_n) // RL1
        meas_valid && src == SRC_CALCULATED |=> st.mag == $past(calc_fund))
        else $error("calculated source not used");

endmodule

/* File: src/threshold_compare.sv */
// ==========================================================
// compare magnitude with threshold and 97 % release level
// ==========================================================
module threshold_compare
    import residual_pickup_pkg::*;
(
    input  wire logic [MAG_W-1:0] magnitude,
    input  wire logic [MAG_W-1:0] threshold,
    output logic                  above_set,
    output logic                  below_release
);
    logic [MAG_W+7:0] mag_scaled;
    logic [MAG_W+7:0] thr_scaled;

    // cross-multiply so no divider is needed
    always_comb
    begin
        mag_scaled    = (MAG_W+8)'(magnitude) * (MAG_W+8)'(HYST_DEN);
        thr_scaled    = (MAG_W+8)'(threshold) * (MAG_W+8)'(HYST_NUM);
        above_set     = magnitude > threshold;
        below_release = mag_scaled < thr_scaled;
    end
endmodule

/* File: tb/residual_overcurrent_pickup_test.sv */
module residual_overcurrent_pickup_test
    import residual_pickup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // settings and signals
    // ==========================================================
    // refresh shortened from 5 ms so the run stays brief
    localparam int               PERIOD = 8;
    localparam int               SETTLE = PERIOD + 6;
    localparam int               LIMIT  = 20000;
    localparam logic [MAG_W-1:0] LOW    = 24'h00_0064;
    localparam logic [MAG_W-1:0] OVER   = THRESHOLD_DEFAULT + 24'h00_0001;
    localparam logic [MAG_W-1:0] REL    = MAG_W'(THRESHOLD_DEFAULT * HYST_NUM / HYST_DEN);

    logic              clk, rst_n, meas_valid, block_in, trip_in, wr, rd, start, blocked, irq;
    logic [MAG_W-1:0]  c_fund, c_true_rms_magnitude, c_pp, s_fund, s_true_rms_magnitude, s_pp, k_fund, level;
    logic [2:0]        sel_ch, ch;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [1:0]        condition;
    int                failures, checks, cycles;

    residual_overcurrent_pickup uut (.clk(clk), .rst_n(rst_n), .coarse_fund(c_fund), .coarse_true_rms_magnitude(c_true_rms_magnitude),
        .coarse_pp(c_pp), .sens_fund(s_fund), .sens_true_rms_magnitude(s_true_rms_magnitude), .sens_pp(s_pp), .calc_fund(k_fund),
        .meas_valid(meas_valid), .block_in(block_in), .trip_in(trip_in), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .start(start), .blocked(blocked), .condition(condition), .irq(irq));

    residual_source_model #(.REFRESH(PERIOD)) source (.clk(clk), .rst_n(rst_n), .sel_ch(sel_ch),
        .level(level), .coarse_fund(c_fund), .coarse_true_rms_magnitude(c_true_rms_magnitude), .coarse_pp(c_pp), .sens_fund(s_fund),
        .sens_true_rms_magnitude(s_true_rms_magnitude), .sens_pp(s_pp), .calc_fund(k_fund), .meas_valid(meas_valid));

    // ==========================================================
    // access and compare tasks
    // ==========================================================
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_chk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, exp, rdata);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // new level waits for a refresh, then for the compare
    task automatic drive(input logic [2:0] c, input logic [MAG_W-1:0] lvl);
        @(posedge clk);
        sel_ch <= c;
        level <= lvl;
        idle(SETTLE);
    endtask

    task automatic state_is(input logic [1:0] c);
        #1;
        check("condition", c, condition);
        check("start", c == COND_START || c == COND_TRIP, start);
        check("blocked", c == COND_BLOCKED, blocked);
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================
    // clock and hang guard
    // ==========================================================
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            $display("BAD cycle_limit expected %0d seen %0d", LIMIT - 1, cycles);
            conclude();
        end
    end

    // ==========================================================
    // test sequence
    // ==========================================================
    initial
    begin
        {rst_n, wr, rd, block_in, trip_in} = '0;
        addr = '0;
        wdata = '0;
        sel_ch = '0;
        level = LOW;
        idle(5);
        rst_n <= 1'b1;
        state_is(COND_NORMAL);
        reg_chk("static", REG_STATIC, 32'h0000_0000);
        reg_chk("threshold", REG_THR_LOCAL, DATA_W'(THRESHOLD_DEFAULT));
        reg_chk("unmapped", 4'hF, 32'h0000_0000);
        $display("test defaults finished");

        reg_wr(REG_IRQ_EN, 32'h0000_000F);
        drive(3'd0, THRESHOLD_DEFAULT);
        state_is(COND_NORMAL);
        drive(3'd0, OVER);
        state_is(COND_START);
        check("irq", 1'b1, irq);
        reg_chk("ratio", REG_RATIO, 32'h0000_03E8);
        drive(3'd0, REL);
        state_is(COND_START);
        drive(3'd0, REL - 24'h00_0001);
        state_is(COND_NORMAL);
        reg_chk("irq_stat", REG_IRQ_STAT, 32'h0000_0003);
        reg_wr(REG_IRQ_CLR, 32'h0000_000F);
        idle(1);
        check("irq", 1'b0, irq);
        $display("test pickup finished");

        // every source and magnitude pairing, then a foreign channel
        for (int s = 0; s < 3; s++)
            for (int m = 0; m < 3; m++)
            begin
                ch = (s == 2) ? 3'd6 : 3'(s * 3 + m);
                reg_wr(REG_STATIC, DATA_W'(m * 4 + s));
                drive(ch, OVER);
                state_is(COND_START);
                drive(3'((ch + 1) % 7), OVER);
                state_is(COND_NORMAL);
            end
        // quiet the coarse channel first so no start event lands in the bus test
        drive(3'd0, LOW);
        reg_wr(REG_STATIC, 32'h0000_0000);
        $display("test selection finished");

        reg_wr(REG_IRQ_CLR, 32'h0000_000F);
        reg_wr(REG_THR_BUS, 32'h0000_1000);
        reg_chk("threshold", REG_THR_LOCAL, DATA_W'(THRESHOLD_DEFAULT));
        reg_chk("irq_stat", REG_IRQ_STAT, 32'h0000_0008);
        reg_wr(REG_STATIC, 32'h0000_0080);
        reg_wr(REG_THR_BUS, 32'h0000_1000);
        reg_chk("threshold", REG_THR_LOCAL, 32'h0000_1000);
        reg_wr(REG_THR_LOCAL, DATA_W'(THRESHOLD_DEFAULT));
        $display("test bus finished");

        reg_wr(REG_GROUP, 32'h0000_0001);
        reg_chk("static", REG_STATIC, 32'h0000_0080);
        reg_chk("threshold", REG_THR_LOCAL, DATA_W'(THRESHOLD_DEFAULT));
        reg_wr(REG_THR_LOCAL, 32'h0000_1000);
        drive(3'd0, 24'h00_1001);
        state_is(COND_START);
        reg_wr(REG_GROUP, 32'h0000_0000);
        idle(SETTLE);
        state_is(COND_NORMAL);
        drive(3'd0, LOW);
        $display("test groups finished");

        // block must be through the sampler before the level rises
        block_in <= 1'b1;
        idle(4);
        drive(3'd0, OVER);
        state_is(COND_BLOCKED);
        reg_chk("status", REG_STATUS, 32'h0000_0033);
        @(posedge clk);
        block_in <= 1'b0;
        idle(8);
        state_is(COND_START);
        @(posedge clk);
        block_in <= 1'b1;
        idle(8);
        state_is(COND_BLOCKED);
        @(posedge clk);
        block_in <= 1'b0;
        idle(8);
        trip_in <= 1'b1;
        idle(4);
        state_is(COND_TRIP);
        @(posedge clk);
        trip_in <= 1'b0;
        $display("test block finished");

        // forcing needs its global enable as well
        reg_wr(REG_STATIC, 32'h0000_0060);
        idle(3);
        state_is(COND_START);
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(REG_STATIC, DATA_W'(32'h0000_0140 | (k << 4)));
            idle(3);
            state_is(2'(k));
        end
        reg_wr(REG_STATIC, 32'h0000_0000);
        drive(3'd0, LOW);
        state_is(COND_NORMAL);
        $display("test forcing finished");
        conclude();
    end
endmodule

/* File: tb/residual_source_model.sv */
// ==========================================================
// measurement chain feeding the pick-up stage
// ==========================================================
module residual_source_model
    import residual_pickup_pkg::*;
#(
    parameter int REFRESH = 8
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [2:0]       sel_ch,
    input  wire logic [MAG_W-1:0] level,
    output logic      [MAG_W-1:0] coarse_fund,
    output logic      [MAG_W-1:0] coarse_true_rms_magnitude,
    output logic      [MAG_W-1:0] coarse_pp,
    output logic      [MAG_W-1:0] sens_fund,
    output logic      [MAG_W-1:0] sens_true_rms_magnitude,
    output logic      [MAG_W-1:0] sens_pp,
    output logic      [MAG_W-1:0] calc_fund,
    output logic                  meas_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // unselected channels carry a small background current
    localparam logic [MAG_W-1:0] BACKGROUND = 24'h00_0064;
    logic [MAG_W-1:0] chan [7];
    int               tick;

    // fixed refresh cadence
    // values move only at a refresh, never between, like the real chain
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick <= 0;
            meas_valid <= 1'b0;
            for (int i = 0; i < 7; i++)
                chan[i] <= BACKGROUND;
        end
        else
        begin
            tick <= (tick == REFRESH - 1) ? 0 : tick + 1;
            meas_valid <= (tick == REFRESH - 1);
            if (tick == REFRESH - 1)
                for (int i = 0; i < 7; i++)
                    chan[i] <= (i == int'(sel_ch)) ? level : BACKGROUND;
        end
    end

    // channel fan-out
    assign coarse_fund = chan[0];
    assign coarse_true_rms_magnitude = chan[1];
    assign coarse_pp   = chan[2];
    assign sens_fund   = chan[3];
    assign sens_true_rms_magnitude   = chan[4];
    assign sens_pp     = chan[5];
    assign calc_fund   = chan[6];
endmodule
